// >>> hw/brg_pkg.sv
`default_nettype none
package brg_pkg;
  // =====================================================
  // register map (byte addresses)
  localparam int          ADDR_W         = 6;
  localparam logic [5:0]  ADDR_CTRL      = 6'h00;
  localparam logic [5:0]  ADDR_POWER     = 6'h04;
  localparam logic [5:0]  ADDR_TAU       = 6'h08;
  localparam logic [5:0]  ADDR_RES       = 6'h0C;
  localparam logic [5:0]  ADDR_UPPER     = 6'h10;
  localparam logic [5:0]  ADDR_LOWER     = 6'h14;
  localparam logic [5:0]  ADDR_STATUS    = 6'h18;
  localparam logic [5:0]  ADDR_TEMP      = 6'h1C;
  localparam logic [5:0]  ADDR_RAW       = 6'h20;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // =====================================================
  // fields
  localparam int          CTRL_MODE_LSB  = 0;
  localparam int          CTRL_CLR_BIT   = 8;
  localparam int          STAT_ALARM     = 0;
  localparam int          STAT_TRIP      = 1;
  localparam int          STAT_INHIBIT   = 2;
  localparam int          STAT_ENABLED   = 3;
  localparam int          STAT_GATE      = 4;
  localparam int          CFG_W          = 16;
  localparam int          VOLT_W         = 11;
  localparam int          PCT_W          = 7;
  // =====================================================
  // reset values
  localparam logic [1:0]  MODE_RST       = 2'h0;
  localparam logic [15:0] CFG_RST        = 16'h0000;
  localparam logic [10:0] UPPER_RST      = 11'h30C;
  localparam logic [10:0] LOWER_RST      = 11'h2F8;
  // =====================================================
  // thermal model scaling: TEMP_FULL is 100 %
  localparam int          TEMP_FRAC      = 20;
  localparam int          TEMP_W         = 23;
  localparam int          DIV_W          = 64;
  localparam int          ON_W           = 20;
  localparam logic [22:0] TEMP_FULL      = 23'h10_0000;
  localparam logic [22:0] TEMP_ALARM     = 23'h0C_0000;
  localparam logic [22:0] TEMP_RESUME    = 23'h0F_3334;
  localparam logic [22:0] HEAT_MAX       = 23'h40_0000;
  localparam logic [29:0] PCT_SCALE      = 30'h0000_0064;
  // =====================================================
  // timing
  localparam int          CLK_PERIOD_NS  = 100;
  localparam int          TICK_PERIOD_NS = 1_000_000;
  localparam int          TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  // =====================================================
  typedef enum logic [1:0] {TH_IDLE, TH_HEAT, TH_STEP} brg_therm_t;
endpackage : brg_pkg
`default_nettype wire

// >>> hw/brg_divider.sv
`timescale 1ns/100ps
`default_nettype none
module brg_divider #(
  parameter int WIDTH = 64
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // request
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] num,
  input  wire logic [WIDTH-1:0] den,
  // answer
  output logic                  done,
  output logic [WIDTH-1:0]      quot
);
  localparam int CW = $clog2(WIDTH + 1);

  logic [WIDTH-1:0] rem_r, rem_nxt, quot_r, quot_nxt;
  logic [CW-1:0]    cnt_r, cnt_nxt;
  logic             busy_r, busy_nxt, done_r, done_nxt;
  logic [WIDTH:0]   shifted;

  // =====================================================
  // restoring division, one quotient bit per cycle
  always_comb begin
    rem_nxt  = rem_r;
    quot_nxt = quot_r;
    cnt_nxt  = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    shifted  = {rem_r, quot_r[WIDTH-1]};
    if (start) begin
      rem_nxt  = '0;
      quot_nxt = num;
      cnt_nxt  = CW'(WIDTH);
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      if (shifted >= {1'b0, den}) begin
        rem_nxt  = WIDTH'(shifted - {1'b0, den});
        quot_nxt = {quot_r[WIDTH-2:0], 1'b1};
      end else begin
        rem_nxt  = shifted[WIDTH-1:0];
        quot_nxt = {quot_r[WIDTH-2:0], 1'b0};
      end
      cnt_nxt = cnt_r - 1'b1;
      if (cnt_r == CW'(1)) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rem_r  <= '0;
      quot_r <= '0;
      cnt_r  <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      rem_r  <= rem_nxt;
      quot_r <= quot_nxt;
      cnt_r  <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
  assign quot = quot_r;
endmodule : brg_divider
`default_nettype wire

// >>> hw/brg_chopper.sv
`timescale 1ns/100ps
`default_nettype none
module brg_chopper #(
  parameter int VW = 11
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // bus voltage and thresholds, volts
  input  wire logic [VW-1:0] busVolts,
  input  wire logic [VW-1:0] upperVolts,
  input  wire logic [VW-1:0] lowerVolts,
  // forced off
  input  wire logic          inhibit,
  // transistor drive
  output logic               gate
);
  logic gate_r, gate_nxt;

  // =====================================================
  // hysteresis on/off control of the braking transistor
  always_comb begin
    gate_nxt = gate_r;
    if (inhibit) begin
      gate_nxt = 1'b0;
    end else if (busVolts > upperVolts) begin
      gate_nxt = 1'b1;
    end else if (busVolts < lowerVolts) begin
      gate_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      gate_r <= 1'b0;
    end else begin
      gate_r <= gate_nxt;
    end
  end

  assign gate = gate_r;
endmodule : brg_chopper
`default_nettype wire

// >>> hw/brg_guard.sv
// Contract
// - protection runs only once rated power, time constant, resistance are set
// - temperature estimate reported as percent, 0 ambient, 100 maximum
// - heat alarm while estimate above 75 percent and transistor active
// - modes 0 and 1 trip when estimate reaches 100 percent
// - modes 2 and 3 inhibit braking at 100 percent until below 95
// - transistor driven in on/off cycles, peak dissipation only when on
// - transistor switched by bus voltage against upper and lower thresholds
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module brg_guard #(
  parameter int TICK_CYCLES = brg_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // bus voltage sample, volts, same clock
  input  wire logic [10:0] dcBusVolts,
  // axi4-lite write
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // protection outputs
  output logic             brakeGate,
  output logic             brakeInhibit,
  output logic             resistorHeatAlarm,
  output logic             resistorOverloadTrip,
  output logic [6:0]       resistorTemperatureEstimate
);
  localparam int DW = brg_pkg::DIV_W;
  localparam int TW = brg_pkg::TEMP_W;

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = data[8*i +: 8];
    end
    return res;
  endfunction : mergeBytes

  // =====================================================
  // bus handshake state
  logic        awTaken_r, awTaken_nxt, wTaken_r, wTaken_nxt;
  logic [5:0]  awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0]  wStrb_r, wStrb_nxt;
  logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        doWrite;
  logic [5:0]  wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;

  // configuration state
  logic [1:0]  mode_r, mode_nxt;
  logic [15:0] power_r, power_nxt, tau_r, tau_nxt, res_r, res_nxt;
  logic [10:0] upper_r, upper_nxt, lower_r, lower_nxt;
  logic        tripClr;

  // thermal state
  brg_pkg::brg_therm_t state_r, state_nxt;
  logic [TW-1:0] temp_r, temp_nxt, heat_r, heat_nxt, heatClamp;
  logic [TW-1:0] diff;
  logic [31:0]   tickCnt_r, tickCnt_nxt;
  logic [19:0]   onCnt_r, onCnt_nxt;
  logic          tick, enabled;
  logic          d1Start, d1Done, d2Start, d2Done;
  logic [DW-1:0] num1, den1, num2, q1, q2;
  logic [21:0]   vSq;

  // protection state
  logic        alarm_r, alarm_nxt, trip_r, trip_nxt;
  logic        inhibit_r, inhibit_nxt;
  logic [6:0]  pct_r, pct_nxt;
  logic [29:0] pctWide;
  logic        gate;

  // =====================================================
  // write channel: address and data in either order
  assign s_axi_awready = !awTaken_r && !bvalid_r;
  assign s_axi_wready  = !wTaken_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;

  always_comb begin
    awTaken_nxt = awTaken_r;
    wTaken_nxt  = wTaken_r;
    awAddr_nxt  = awAddr_r;
    wData_nxt   = wData_r;
    wStrb_nxt   = wStrb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      awTaken_nxt = 1'b1;
      awAddr_nxt  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wTaken_nxt = 1'b1;
      wData_nxt  = s_axi_wdata;
      wStrb_nxt  = s_axi_wstrb;
    end
    doWrite = awTaken_nxt && wTaken_nxt && !bvalid_r;
    wrAddr  = awAddr_nxt;
    wrData  = wData_nxt;
    wrStrb  = wStrb_nxt;
    if (doWrite) begin
      awTaken_nxt = 1'b0;
      wTaken_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      if (wrAddr <= brg_pkg::ADDR_LOWER && wrAddr[1:0] == 2'h0) begin
        bresp_nxt = brg_pkg::RESP_OKAY;
      end else begin
        bresp_nxt = brg_pkg::RESP_SLVERR;
      end
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // =====================================================
  // read channel: answer one cycle after the address is taken
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = brg_pkg::RESP_OKAY;
      rdata_nxt  = 32'h0000_0000;
      if (s_axi_araddr == brg_pkg::ADDR_CTRL) begin
        rdata_nxt[brg_pkg::CTRL_MODE_LSB +: 2] = mode_r;
      end else if (s_axi_araddr == brg_pkg::ADDR_POWER) begin
        rdata_nxt[15:0] = power_r;
      end else if (s_axi_araddr == brg_pkg::ADDR_TAU) begin
        rdata_nxt[15:0] = tau_r;
      end else if (s_axi_araddr == brg_pkg::ADDR_RES) begin
        rdata_nxt[15:0] = res_r;
      end else if (s_axi_araddr == brg_pkg::ADDR_UPPER) begin
        rdata_nxt[10:0] = upper_r;
      end else if (s_axi_araddr == brg_pkg::ADDR_LOWER) begin
        rdata_nxt[10:0] = lower_r;
      end else if (s_axi_araddr == brg_pkg::ADDR_STATUS) begin
        rdata_nxt[brg_pkg::STAT_ALARM]   = alarm_r;
        rdata_nxt[brg_pkg::STAT_TRIP]    = trip_r;
        rdata_nxt[brg_pkg::STAT_INHIBIT] = inhibit_r;
        rdata_nxt[brg_pkg::STAT_ENABLED] = enabled;
        rdata_nxt[brg_pkg::STAT_GATE]    = gate;
      end else if (s_axi_araddr == brg_pkg::ADDR_TEMP) begin
        rdata_nxt[6:0] = pct_r;
      end else if (s_axi_araddr == brg_pkg::ADDR_RAW) begin
        rdata_nxt[TW-1:0] = temp_r;
      end else begin
        rresp_nxt = brg_pkg::RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  // =====================================================
  // configuration registers
  always_comb begin
    logic [31:0] m;
    m         = 32'h0000_0000;
    mode_nxt  = mode_r;
    power_nxt = power_r;
    tau_nxt   = tau_r;
    res_nxt   = res_r;
    upper_nxt = upper_r;
    lower_nxt = lower_r;
    tripClr   = 1'b0;
    if (doWrite) begin
      if (wrAddr == brg_pkg::ADDR_CTRL) begin
        m        = mergeBytes({30'h0, mode_r}, wrData, wrStrb);
        mode_nxt = m[brg_pkg::CTRL_MODE_LSB +: 2];
        tripClr  = wrStrb[1] && wrData[brg_pkg::CTRL_CLR_BIT];
      end else if (wrAddr == brg_pkg::ADDR_POWER) begin
        m         = mergeBytes({16'h0, power_r}, wrData, wrStrb);
        power_nxt = m[15:0];
      end else if (wrAddr == brg_pkg::ADDR_TAU) begin
        m       = mergeBytes({16'h0, tau_r}, wrData, wrStrb);
        tau_nxt = m[15:0];
      end else if (wrAddr == brg_pkg::ADDR_RES) begin
        m       = mergeBytes({16'h0, res_r}, wrData, wrStrb);
        res_nxt = m[15:0];
      end else if (wrAddr == brg_pkg::ADDR_UPPER) begin
        m         = mergeBytes({21'h0, upper_r}, wrData, wrStrb);
        upper_nxt = m[10:0];
      end else if (wrAddr == brg_pkg::ADDR_LOWER) begin
        m         = mergeBytes({21'h0, lower_r}, wrData, wrStrb);
        lower_nxt = m[10:0];
      end
    end
  end

  // =====================================================
  // thermal model, updated once per tick
  assign enabled = (power_r != 16'h0000) && (tau_r != 16'h0000)
                   && (res_r != 16'h0000);
  assign tick    = (tickCnt_r == 32'(TICK_CYCLES - 1));
  assign vSq     = 22'(dcBusVolts) * 22'(dcBusVolts);
  // energy this tick over rated energy, scaled to full
  assign num1    = (DW'(vSq) * DW'(onCnt_r)) << brg_pkg::TEMP_FRAC;
  assign den1    = DW'(res_r) * DW'(power_r) * DW'(TICK_CYCLES);
  assign heatClamp = (q1 > DW'(brg_pkg::HEAT_MAX)) ? brg_pkg::HEAT_MAX
                                                   : q1[TW-1:0];
  assign diff    = (heatClamp >= temp_r) ? heatClamp - temp_r
                                         : temp_r - heatClamp;
  // rounded up so the estimate settles exactly
  assign num2    = DW'(diff) + DW'(tau_r) - DW'(1);

  always_comb begin
    state_nxt   = state_r;
    temp_nxt    = temp_r;
    heat_nxt    = heat_r;
    d1Start     = 1'b0;
    d2Start     = 1'b0;
    tickCnt_nxt = tick ? 32'h0000_0000 : tickCnt_r + 32'h0000_0001;
    onCnt_nxt   = tick ? 20'h0_0000 : onCnt_r;
    if (gate && onCnt_nxt != 20'hF_FFFF) begin
      onCnt_nxt = onCnt_nxt + 20'h0_0001;
    end
    case (state_r)
      brg_pkg::TH_IDLE: begin
        if (enabled && tick) begin
          d1Start   = 1'b1;
          state_nxt = brg_pkg::TH_HEAT;
        end
      end
      brg_pkg::TH_HEAT: begin
        if (d1Done) begin
          heat_nxt  = heatClamp;
          d2Start   = 1'b1;
          state_nxt = brg_pkg::TH_STEP;
        end
      end
      brg_pkg::TH_STEP: begin
        if (d2Done) begin
          if (heat_r >= temp_r) begin
            temp_nxt = temp_r + q2[TW-1:0];
            if (temp_nxt > brg_pkg::TEMP_FULL) begin
              temp_nxt = brg_pkg::TEMP_FULL;
            end
          end else begin
            temp_nxt = temp_r - q2[TW-1:0];
          end
          state_nxt = brg_pkg::TH_IDLE;
        end
      end
      default: state_nxt = brg_pkg::TH_IDLE;
    endcase
    if (!enabled) begin
      temp_nxt  = '0;
      state_nxt = brg_pkg::TH_IDLE;
    end
  end

  // =====================================================
  // alarm, trip and inhibit
  assign pctWide = 30'(temp_r) * brg_pkg::PCT_SCALE;

  always_comb begin
    pct_nxt   = pctWide[brg_pkg::TEMP_FRAC +: 7];
    alarm_nxt = enabled && gate
                && (temp_r > brg_pkg::TEMP_ALARM);
    trip_nxt  = trip_r && !tripClr;
    if (enabled && !mode_r[1] && temp_r >= brg_pkg::TEMP_FULL) begin
      trip_nxt = 1'b1;
    end
    inhibit_nxt = inhibit_r;
    if (!enabled || !mode_r[1]) begin
      inhibit_nxt = 1'b0;
    end else if (temp_r >= brg_pkg::TEMP_FULL) begin
      inhibit_nxt = 1'b1;
    end else if (temp_r < brg_pkg::TEMP_RESUME) begin
      inhibit_nxt = 1'b0;
    end
  end

  // =====================================================
  always_ff @(posedge clk) begin
    if (reset) begin
      awTaken_r <= 1'b0;
      wTaken_r  <= 1'b0;
      awAddr_r  <= '0;
      wData_r   <= '0;
      wStrb_r   <= '0;
      bvalid_r  <= 1'b0;
      bresp_r   <= brg_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rdata_r   <= '0;
      rresp_r   <= brg_pkg::RESP_OKAY;
      mode_r    <= brg_pkg::MODE_RST;
      power_r   <= brg_pkg::CFG_RST;
      tau_r     <= brg_pkg::CFG_RST;
      res_r     <= brg_pkg::CFG_RST;
      upper_r   <= brg_pkg::UPPER_RST;
      lower_r   <= brg_pkg::LOWER_RST;
      state_r   <= brg_pkg::TH_IDLE;
      temp_r    <= '0;
      heat_r    <= '0;
      tickCnt_r <= '0;
      onCnt_r   <= '0;
      alarm_r   <= 1'b0;
      trip_r    <= 1'b0;
      inhibit_r <= 1'b0;
      pct_r     <= '0;
    end else begin
      awTaken_r <= awTaken_nxt;
      wTaken_r  <= wTaken_nxt;
      awAddr_r  <= awAddr_nxt;
      wData_r   <= wData_nxt;
      wStrb_r   <= wStrb_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      mode_r    <= mode_nxt;
      power_r   <= power_nxt;
      tau_r     <= tau_nxt;
      res_r     <= res_nxt;
      upper_r   <= upper_nxt;
      lower_r   <= lower_nxt;
      state_r   <= state_nxt;
      temp_r    <= temp_nxt;
      heat_r    <= heat_nxt;
      tickCnt_r <= tickCnt_nxt;
      onCnt_r   <= onCnt_nxt;
      alarm_r   <= alarm_nxt;
      trip_r    <= trip_nxt;
      inhibit_r <= inhibit_nxt;
      pct_r     <= pct_nxt;
    end
  end

  // =====================================================
  brg_divider #(.WIDTH(DW)) u_heatDiv (
    .clk   (clk),
    .reset (reset),
    .start (d1Start),
    .num   (num1),
    .den   (den1),
    .done  (d1Done),
    .quot  (q1)
  );

  brg_divider #(.WIDTH(DW)) u_stepDiv (
    .clk   (clk),
    .reset (reset),
    .start (d2Start),
    .num   (num2),
    .den   (DW'(tau_r)),
    .done  (d2Done),
    .quot  (q2)
  );

  // a trip also stops braking
  brg_chopper #(.VW(brg_pkg::VOLT_W)) u_chopper (
    .clk        (clk),
    .reset      (reset),
    .busVolts   (dcBusVolts),
    .upperVolts (upper_r),
    .lowerVolts (lower_r),
    .inhibit    (inhibit_r || trip_r),
    .gate       (gate)
  );

  assign brakeGate                   = gate;
  assign brakeInhibit                = inhibit_r;
  assign resistorHeatAlarm           = alarm_r;
  assign resistorOverloadTrip        = trip_r;
  assign resistorTemperatureEstimate = pct_r;
endmodule : brg_guard
`default_nettype wire

// >>> tb/brg_guard_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module brg_guard_assertions (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // bus side
  input wire logic [10:0] dcBusVolts,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // protection
  input wire logic        brakeGate,
  input wire logic        brakeInhibit,
  input wire logic        resistorHeatAlarm,
  input wire logic        resistorOverloadTrip,
  input wire logic [6:0]  resistorTemperatureEstimate
);
  // ====
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  logic [6:0] pct;
  logic       trp;
  assign pct = resistorTemperatureEstimate;
  assign trp = resistorOverloadTrip;
  chk_pct_range: assert property (pct <= 7'h64)
    else $error("estimate above full scale");
  // percent truncates, so just above 75 reads as 75
  chk_alarm_hot: assert property (resistorHeatAlarm |-> pct >= 7'h4B)
    else $error("alarm while estimate not above 75");
  chk_trip_full: assert property ($rose(trp) |-> pct == 7'h64)
    else $error("trip before full estimate");
  chk_trip_sticky: assert property
    (trp && !s_axi_wvalid && !$past(s_axi_wvalid) |=> trp)
    else $error("trip cleared without a write");
  chk_inhib_full: assert property ($rose(brakeInhibit) |-> pct == 7'h64)
    else $error("inhibit before full estimate");
  chk_inhib_release: assert property ($fell(brakeInhibit) |-> pct < 7'h5F)
    else $error("inhibit released at or above 95");
  chk_gate_blocked: assert property
    (trp || brakeInhibit |=> !brakeGate)
    else $error("gate on while blocked");
  chk_gate_rise: assert property
    ($rose(brakeGate) |-> $past(dcBusVolts) > brg_pkg::UPPER_RST)
    else $error("gate rose without bus above upper");
  chk_gate_fall: assert property ($fell(brakeGate) && !trp &&
    !brakeInhibit && !$past(trp) && !$past(brakeInhibit)
    |-> $past(dcBusVolts) < brg_pkg::LOWER_RST)
    else $error("gate fell without bus below lower");
  chk_read_answer: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cov_trip: cover property ($rose(trp));
  cov_inhib: cover property ($fell(brakeInhibit));
  cov_alarm: cover property ($rose(resistorHeatAlarm));
endmodule : brg_guard_assertions
bind brg_guard brg_guard_assertions brg_guard_assertions_i (.*);
`default_nettype wire

// >>> tb/brg_guard_tb.sv
`timescale 1ns/100ps
`default_nettype none
module brg_guard_tb;
  // ====
  // ports
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [10:0] dcBusVolts = 11'h000;
  logic [5:0]  s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        brakeGate, brakeInhibit;
  logic        resistorHeatAlarm, resistorOverloadTrip;
  logic [6:0]  resistorTemperatureEstimate;
  int          num_errors = 0;
  int          check_count = 0;
  int          cycles = 0;
  // tick must outlast the two 64-cycle divides or updates are skipped
  brg_guard #(.TICK_CYCLES(200)) brg_guard_i (.*);
  always #50 clk = ~clk;
  // ====
  // helpers
  task automatic end_sim();
    if (num_errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic pa, pw, t;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa | pw) begin
      @(negedge clk);
      pa = pa & ~s_axi_awready;
      pw = pw & ~s_axi_wready;
      @(posedge clk);
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do begin
      @(negedge clk);
      t = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
    end while (!t);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic t;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
    end while (!t);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge clk);
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
    end while (!t);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic setv(input logic [10:0] v);
    @(posedge clk);
    dcBusVolts <= v;
    @(posedge clk);
    @(negedge clk);
  endtask : setv
  // ====
  // scenarios
  task automatic test_regs();
    logic [31:0] d;
    logic [1:0]  r;
    rd(brg_pkg::ADDR_CTRL, d, r);
    chk("mode reset", d, 32'h0000_0000);
    rd(brg_pkg::ADDR_UPPER, d, r);
    chk("upper reset", d, 32'h0000_030C);
    rd(brg_pkg::ADDR_LOWER, d, r);
    chk("lower reset", d, 32'h0000_02F8);
    rd(brg_pkg::ADDR_POWER, d, r);
    chk("power reset", d, 32'h0000_0000);
    rd(6'h24, d, r);
    chk("unmapped resp", r, brg_pkg::RESP_SLVERR);
    chk("unmapped data", d, 32'h0000_0000);
    wr(brg_pkg::ADDR_STATUS, 32'h0000_001F, r);
    chk("status write", r, brg_pkg::RESP_SLVERR);
    wr(brg_pkg::ADDR_LOWER, 32'h0000_0123, r);
    rd(brg_pkg::ADDR_LOWER, d, r);
    chk("lower write", d, 32'h0000_0123);
    wr(brg_pkg::ADDR_LOWER, 32'h0000_02F8, r);
  endtask : test_regs
  task automatic test_hyst();
    logic [10:0] v [8] = '{11'h320, 11'h302, 11'h2EE, 11'h302,
                           11'h30C, 11'h30D, 11'h2F8, 11'h2F7};
    logic [7:0]  g = 8'h63;
    for (int i = 0; i < 8; i++) begin
      setv(v[i]);
      chk("gate", brakeGate, g[i]);
    end
    setv(11'h320);
    repeat (300) @(negedge clk);
    chk("disabled estimate", resistorTemperatureEstimate, 0);
    chk("disabled trip", resistorOverloadTrip, 0);
    setv(11'h2EE);
  endtask : test_hyst
  task automatic test_trip(input logic [1:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    logic        al = 1'b0;
    wr(brg_pkg::ADDR_POWER, 32'h0000_0320, r);
    wr(brg_pkg::ADDR_TAU, 32'h0000_0004, r);
    wr(brg_pkg::ADDR_RES, 32'h0000_0190, r);
    wr(brg_pkg::ADDR_CTRL, {30'h0, m}, r);
    setv(11'h320);
    for (int n = 0; n < 2000 && resistorOverloadTrip !== 1'b1; n++) begin
      @(negedge clk);
      al = al | (resistorHeatAlarm === 1'b1);
    end
    chk("trip", resistorOverloadTrip, 1);
    chk("alarm seen", al, 1);
    chk("estimate full", resistorTemperatureEstimate, 7'h64);
    @(negedge clk);
    chk("gate tripped", brakeGate, 0);
    rd(brg_pkg::ADDR_STATUS, d, r);
    chk("status trip", d[brg_pkg::STAT_TRIP], 1);
    setv(11'h2EE);
    // one more update still sees the on time, the next one cools
    repeat (500) @(negedge clk);
    chk("trip held", resistorOverloadTrip, 1);
    chk("cooled", resistorTemperatureEstimate < 7'h64, 1);
    wr(brg_pkg::ADDR_CTRL, {30'h0000_0040, m}, r);
    @(negedge clk);
    chk("trip cleared", resistorOverloadTrip, 0);
  endtask : test_trip
  task automatic test_inhib(input logic [1:0] m);
    logic [1:0] r;
    wr(brg_pkg::ADDR_CTRL, {30'h0, m}, r);
    setv(11'h320);
    for (int n = 0; n < 2000 && brakeInhibit !== 1'b1; n++) @(negedge clk);
    chk("inhibit", brakeInhibit, 1);
    chk("no trip", resistorOverloadTrip, 0);
    @(negedge clk);
    chk("gate inhibited", brakeGate, 0);
    for (int n = 0; n < 2000 && brakeInhibit !== 1'b0; n++) @(negedge clk);
    chk("released", brakeInhibit, 0);
    chk("below 95", resistorTemperatureEstimate < 7'h5F, 1);
    for (int n = 0; n < 4 && brakeGate !== 1'b1; n++) @(negedge clk);
    chk("gate back", brakeGate, 1);
    setv(11'h2EE);
    repeat (150) @(negedge clk);
  endtask : test_inhib
  // ====
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    test_regs();
    test_hyst();
    test_trip(2'h0);
    test_trip(2'h1);
    test_inhib(2'h2);
    test_inhib(2'h3);
    end_sim();
  end
endmodule : brg_guard_tb
`default_nettype wire
